//--- field_policy_pkg.sv
package field_policy_pkg;

	// ****************************************************************
	// Access classes
	// ****************************************************************
	typedef enum logic [3:0] {
		ACC_WRITE_IGNORED,
		ACC_MUST_BE_ZERO,
		ACC_READ_AS_ZERO,
		ACC_READ_CLEARS,
		ACC_RESERVED_FIELD,
		ACC_READ_ONLY,
		ACC_READ_WRITE,
		ACC_W1C,
		ACC_W1S,
		ACC_WRITE_ONLY
	} access_class_t;

	// ****************************************************************
	// Bus geometry
	// ****************************************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NUM_REGS = 10;

	// ****************************************************************
	// Register offsets (one word per access class demonstrator, then interrupt status and mask)
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_IGNORED = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MUST_BE_ZERO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_READ_AS_ZERO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RC = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_RESERVED = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RO = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RW = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_W1C = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_W1S = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_WO = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h2c;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [DATA_W-1:0] RST_RO = 32'h0000_00a5;
	localparam logic [DATA_W-1:0] RST_RW = 32'h0000_0001;
	localparam logic [DATA_W-1:0] RST_WO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RD_UNPRED = 32'hdead_beef;

	// ****************************************************************
	// Interrupt status bits
	// ****************************************************************
	localparam int IRQ_W = 3;
	localparam int IRQ_ILLEGAL_OPERAND = 0;
	localparam int IRQ_RC_EVENT = 1;
	localparam int IRQ_W1C_EVENT = 2;

endpackage : field_policy_pkg

//--- register_field_access_policy.sv
`timescale 1ns/1ps

module register_field_access_policy #(
	parameter int W1C_READABLE = 1,
	parameter int W1S_READABLE = 1
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port
	input wire logic [field_policy_pkg::ADDR_W-1:0] addr_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [field_policy_pkg::DATA_W-1:0] rdata_out,
	// Hardware side
	input wire logic [field_policy_pkg::DATA_W-1:0] hw_ro_value_in,
	input wire logic hw_ro_load_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] hw_rc_set_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] hw_w1c_set_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] hw_zero_field_in,
	output logic [field_policy_pkg::DATA_W-1:0] rw_value_out,
	output logic [field_policy_pkg::DATA_W-1:0] w1s_value_out,
	output logic [field_policy_pkg::DATA_W-1:0] wo_value_out,
	// Exceptions
	output logic illegal_operand_out,
	output logic irq_out
);
	import field_policy_pkg::*;

	// ****************************************************************
	// Field classification
	// ****************************************************************

	// Map offset to access class; unmapped gives reserved
	function automatic access_class_t class_of(logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_IGNORED: class_of = ACC_WRITE_IGNORED;
			OFS_MUST_BE_ZERO: class_of = ACC_MUST_BE_ZERO;
			OFS_READ_AS_ZERO: class_of = ACC_READ_AS_ZERO;
			OFS_RC: class_of = ACC_READ_CLEARS;
			OFS_RO: class_of = ACC_READ_ONLY;
			OFS_RW: class_of = ACC_READ_WRITE;
			OFS_W1C: class_of = ACC_W1C;
			OFS_W1S: class_of = ACC_W1S;
			OFS_WO: class_of = ACC_WRITE_ONLY;
			default: class_of = ACC_RESERVED_FIELD;
		endcase
	endfunction : class_of

	// True when software writes may change the field
	function automatic logic sw_writable(access_class_t c);
		sw_writable = (c == ACC_READ_WRITE) || (c == ACC_W1C) ||
			(c == ACC_W1S) || (c == ACC_WRITE_ONLY);
	endfunction : sw_writable

	access_class_t wr_class;
	access_class_t rd_class;
	logic wr_ok;
	logic [DATA_W-1:0] rw_q;
	logic [DATA_W-1:0] ro_q;
	logic [DATA_W-1:0] rc_q;
	logic [DATA_W-1:0] w1c_q;
	logic [DATA_W-1:0] w1s_q;
	logic [DATA_W-1:0] wo_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_event;
	logic illegal_d;
	logic illegal_q;
	logic irq_q;
	logic stat_wr;
	logic mask_wr;

	// Per-field gating derived from static class
	assign wr_class = class_of(addr_in);
	assign rd_class = class_of(addr_in);
	assign wr_ok = wr_in && sw_writable(wr_class);
	assign stat_wr = wr_in && (addr_in == OFS_IRQ_STAT);
	assign mask_wr = wr_in && (addr_in == OFS_IRQ_MASK);

	// ****************************************************************
	// Field storage
	// ****************************************************************

	// Read/write field
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rw_q <= RST_RW;
		end else if (wr_ok && wr_class == ACC_READ_WRITE) begin
			rw_q <= wdata_in;
		end
	end

	// Read-only field, hardware loaded only
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ro_q <= RST_RO;
		end else if (hw_ro_load_in) begin
			ro_q <= hw_ro_value_in;
		end
	end

	// Clear-on-read field; hardware set wins over read clear
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rc_q <= RST_ZERO;
		end else if (rd_in && rd_class == ACC_READ_CLEARS) begin
			rc_q <= hw_rc_set_in;
		end else begin
			rc_q <= rc_q | hw_rc_set_in;
		end
	end

	// Write-one-to-clear bits; hardware set wins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			w1c_q <= RST_ZERO;
		end else if (wr_ok && wr_class == ACC_W1C) begin
			w1c_q <= (w1c_q & ~wdata_in) | hw_w1c_set_in;
		end else begin
			w1c_q <= w1c_q | hw_w1c_set_in;
		end
	end

	// Write-one-to-set bits
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			w1s_q <= RST_ZERO;
		end else if (wr_ok && wr_class == ACC_W1S) begin
			w1s_q <= w1s_q | wdata_in;
		end
	end

	// Write-only field
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wo_q <= RST_WO;
		end else if (wr_ok && wr_class == ACC_WRITE_ONLY) begin
			wo_q <= wdata_in;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Read data mux by class
	always_comb begin
		rdata_d = RD_UNMAPPED;
		illegal_d = 1'b0;
		if (addr_in == OFS_IRQ_STAT) begin
			rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
		end else if (addr_in == OFS_IRQ_MASK) begin
			rdata_d = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
		end else begin
			unique case (rd_class)
				ACC_WRITE_IGNORED: rdata_d = RST_ZERO;
				ACC_MUST_BE_ZERO: begin
					rdata_d = hw_zero_field_in;
					illegal_d = rd_in && (hw_zero_field_in != RST_ZERO);
				end
				ACC_READ_AS_ZERO: rdata_d = RST_ZERO;
				ACC_READ_CLEARS: rdata_d = rc_q;
				ACC_RESERVED_FIELD: rdata_d = RD_UNMAPPED;
				ACC_READ_ONLY: rdata_d = ro_q;
				ACC_READ_WRITE: rdata_d = rw_q;
				ACC_W1C: rdata_d = (W1C_READABLE != 0) ? w1c_q : RD_UNPRED;
				ACC_W1S: rdata_d = (W1S_READABLE != 0) ? w1s_q : RD_UNPRED;
				ACC_WRITE_ONLY: rdata_d = RST_ZERO;
			endcase
		end
	end

	// Read data register, valid the cycle after rd_in
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_q <= RST_ZERO;
		end else if (rd_in) begin
			rdata_q <= rdata_d;
		end
	end

	// Illegal-operand pulse
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			illegal_q <= 1'b0;
		end else begin
			illegal_q <= illegal_d;
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************

	// Events feeding the sticky status
	always_comb begin
		irq_event = '0;
		irq_event[IRQ_ILLEGAL_OPERAND] = illegal_d;
		irq_event[IRQ_RC_EVENT] = |hw_rc_set_in;
		irq_event[IRQ_W1C_EVENT] = |hw_w1c_set_in;
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			irq_stat_q <= '0;
		end else if (stat_wr) begin
			irq_stat_q <= (irq_stat_q & ~wdata_in[IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_q <= irq_stat_q | irq_event;
		end
	end

	// Interrupt mask
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			irq_mask_q <= '0;
		end else if (mask_wr) begin
			irq_mask_q <= wdata_in[IRQ_W-1:0];
		end
	end

	// Registered interrupt level
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Outputs straight from flops
	assign rdata_out = rdata_q;
	assign rw_value_out = rw_q;
	assign w1s_value_out = w1s_q;
	assign wo_value_out = wo_q;
	assign illegal_operand_out = illegal_q;
	assign irq_out = irq_q;

endmodule : register_field_access_policy

//--- field_policy_sva.sv
`timescale 1ns/1ps
module field_policy_sva
	import field_policy_pkg::*;
(
	// Clock, reset and register port
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [field_policy_pkg::ADDR_W-1:0] addr_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] rdata_out,
	// Field contents and exception
	input wire logic [field_policy_pkg::DATA_W-1:0] hw_zero_field_in,
	input wire logic [field_policy_pkg::DATA_W-1:0] rw_value_out,
	input wire logic [field_policy_pkg::DATA_W-1:0] w1s_value_out,
	input wire logic [field_policy_pkg::DATA_W-1:0] wo_value_out,
	input wire logic illegal_operand_out
);
	// ****
	// Field access properties
	// ****
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_raz_read: assert property (rd_in && addr_in == OFS_READ_AS_ZERO |=>
		rdata_out == RST_ZERO) else $error("zero field read nonzero");
	a_wo_read: assert property (rd_in && addr_in == OFS_WO |=>
		rdata_out == RST_ZERO) else $error("write-only field readable");
	a_rw_store: assert property (wr_in && addr_in == OFS_RW |=>
		rw_value_out == $past(wdata_in)) else $error("rw not stored");
	a_rw_hold: assert property (!(wr_in && addr_in == OFS_RW) |=>
		$stable(rw_value_out)) else $error("rw changed without write");
	a_wo_store: assert property (wr_in && addr_in == OFS_WO |=>
		wo_value_out == $past(wdata_in)) else $error("wo not stored");
	a_w1s_set: assert property (wr_in && addr_in == OFS_W1S |=>
		&(w1s_value_out | ~$past(wdata_in))) else $error("w1s not set");
	a_w1s_keep: assert property (wr_in && addr_in == OFS_W1S |=>
		((w1s_value_out ^ $past(w1s_value_out)) & ~$past(wdata_in)) == '0)
		else $error("w1s zero bits changed");
	a_zero_raise: assert property (rd_in && addr_in == OFS_MUST_BE_ZERO &&
		hw_zero_field_in != '0 |=> illegal_operand_out ##1 !illegal_operand_out)
		else $error("no illegal operand pulse");
	a_zero_cause: assert property (illegal_operand_out |->
		$past(rd_in && addr_in == OFS_MUST_BE_ZERO && hw_zero_field_in != '0))
		else $error("illegal operand without cause");
	// Main scenarios reached
	c_illegal: cover property (illegal_operand_out);
	c_rc_read: cover property (rd_in && addr_in == OFS_RC);
	c_w1s_write: cover property (wr_in && addr_in == OFS_W1S);
endmodule : field_policy_sva

bind register_field_access_policy field_policy_sva u_sva (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .hw_zero_field_in(hw_zero_field_in),
	.rw_value_out(rw_value_out), .w1s_value_out(w1s_value_out),
	.wo_value_out(wo_value_out), .illegal_operand_out(illegal_operand_out));

//--- tb_register_field_access_policy.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	err_count++; $display("CHECK FAILED %0t: got %h exp %h", $time, a, b); \
	end end
module tb_register_field_access_policy;
	import field_policy_pkg::*;
	logic clk_sys_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, rd_p = 0;
	logic hw_ro_load_in = 0, illegal_operand_out, irq_out;
	logic [ADDR_W-1:0] addr_in = '0;
	logic [DATA_W-1:0] wdata_in = '0, hw_ro_value_in = '0, hw_rc_set_in = '0;
	logic [DATA_W-1:0] hw_w1c_set_in = '0, hw_zero_field_in = '0, r, e;
	logic [DATA_W-1:0] rdata_out, rw_value_out, w1s_value_out, wo_value_out;
	logic [DATA_W-1:0] exp_q[$];
	int err_count = 0, checks_done = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	register_field_access_policy u_dut (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.hw_ro_value_in(hw_ro_value_in), .hw_ro_load_in(hw_ro_load_in),
		.hw_rc_set_in(hw_rc_set_in), .hw_w1c_set_in(hw_w1c_set_in),
		.hw_zero_field_in(hw_zero_field_in), .rw_value_out(rw_value_out),
		.w1s_value_out(w1s_value_out), .wo_value_out(wo_value_out),
		.illegal_operand_out(illegal_operand_out), .irq_out(irq_out));
	// ****
	// Bus tasks and read monitor
	// ****
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clk_sys_in);
		wr_in <= w;
		rd_in <= !w;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
	endtask : bus
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		exp_q.push_back(x);
		bus(1'b0, a, '0);
	endtask : rd
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// Read data compared in the cycle after the strobe
	always @(posedge clk_sys_in) rd_p <= rd_in;
	always @(negedge clk_sys_in) begin
		if (rd_p) begin
			e = exp_q.pop_front();
			`CHK(rdata_out, e)
		end
	end
	// Hang guard
	initial begin
		#100us;
		err_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h838e));
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(OFS_RO, RST_RO);
		rd(OFS_RW, RST_RW);
		`CHK(wo_value_out, RST_WO)
		r = $urandom();
		bus(1'b1, OFS_IGNORED, r);
		bus(1'b1, OFS_READ_AS_ZERO, r);
		bus(1'b1, OFS_RO, r);
		bus(1'b1, OFS_RESERVED, '0);
		bus(1'b1, OFS_MUST_BE_ZERO, '0);
		rd(OFS_RESERVED, RD_UNMAPPED);
		rd(OFS_IGNORED, RST_ZERO);
		rd(OFS_READ_AS_ZERO, RST_ZERO);
		rd(OFS_RO, RST_RO);
		rd(8'hf0, RD_UNMAPPED);
		`CHK(rw_value_out, RST_RW)
		hw_ro_value_in <= r;
		hw_ro_load_in <= 1'b1;
		@(posedge clk_sys_in);
		hw_ro_load_in <= 1'b0;
		rd(OFS_RO, r);
		repeat (4) begin
			r = $urandom();
			bus(1'b1, OFS_RW, r);
			rd(OFS_RW, r);
		end
		hw_zero_field_in <= 32'h0000_0100;
		rd(OFS_MUST_BE_ZERO, 32'h0000_0100);
		hw_rc_set_in <= 32'h0000_0f0f;
		hw_w1c_set_in <= 32'h0000_00ff;
		@(posedge clk_sys_in);
		hw_rc_set_in <= '0;
		hw_w1c_set_in <= '0;
		bus(1'b1, OFS_RC, '1);
		rd(OFS_RC, 32'h0000_0f0f);
		rd(OFS_RC, RST_ZERO);
		bus(1'b1, OFS_W1C, 32'h0000_000f);
		rd(OFS_W1C, 32'h0000_00f0);
		bus(1'b1, OFS_W1C, '0);
		rd(OFS_W1C, 32'h0000_00f0);
		bus(1'b1, OFS_W1S, 32'h0000_0003);
		bus(1'b1, OFS_W1S, 32'h0000_0004);
		rd(OFS_W1S, 32'h0000_0007);
		r = $urandom();
		bus(1'b1, OFS_WO, r);
		rd(OFS_WO, RST_ZERO);
		`CHK(wo_value_out, r)
		rd(OFS_IRQ_STAT, 32'h0000_0007);
		`CHK(irq_out, 1'b0)
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
		@(posedge clk_sys_in);
		@(negedge clk_sys_in);
		`CHK(irq_out, 1'b1)
		bus(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
		@(posedge clk_sys_in);
		@(negedge clk_sys_in);
		`CHK(irq_out, 1'b0)
		rd(OFS_IRQ_STAT, 32'h0000_0005);
		repeat (3) @(posedge clk_sys_in);
		tally_and_finish();
	end
endmodule : tb_register_field_access_policy
